// ==== common/acr_pkg.sv ====
// Package for the converter control register block.
// Assumes one 20 MHz clock and a plain register port.
package acr_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] OFF_PIN_SEL   = 4'h8;
	localparam logic [3:0] OFF_CONTROL   = 4'h9;
	localparam logic [3:0] OFF_TRIM      = 4'hA;
	localparam logic [3:0] OFF_RES_UPPER = 4'hB;
	localparam logic [3:0] OFF_RES_TOP   = 4'hC;
	localparam logic [3:0] OFF_RES_LOW   = 4'hD;
	localparam logic [3:0] OFF_IRQ_STAT  = 4'hE;
	localparam logic [3:0] OFF_IRQ_MASK  = 4'hF;

	// ==========================================================
	// Field positions
	localparam int POS_REF_SEL  = 7;
	localparam int POS_DIV_HI   = 6;
	localparam int POS_DIV_LO   = 5;
	localparam int POS_GO       = 4;
	localparam int POS_POWER    = 3;
	localparam int POS_CAL_EN   = 7;
	localparam int POS_SIGN     = 6;
	localparam int POS_MAG_HI   = 5;
	localparam int POS_MAG_LO   = 3;
	localparam int POS_DONE     = 5;

	localparam logic [7:0] MASK_PIN_SEL = 8'h0F;
	localparam logic [7:0] MASK_CONTROL = 8'hFB;
	localparam logic [7:0] MASK_TRIM    = 8'hF8;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_PIN_SEL = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_TRIM    = 8'h00;
	localparam logic [7:0] RST_MASK    = 8'h00;

	// ==========================================================
	// Clock divider codes
	localparam logic [1:0] DIV_16   = 2'h0;
	localparam logic [1:0] DIV_4    = 2'h1;
	localparam logic [1:0] DIV_64   = 2'h2;
	localparam logic [1:0] DIV_RING = 2'h3;
	localparam int DIV_16_N = 16;
	localparam int DIV_4_N  = 4;
	localparam int DIV_64_N = 64;

	// ==========================================================
	// Settings that travel together to the converter core
	typedef struct packed {
		logic [1:0] channel;
		logic [1:0] divider;
		logic       cal_en;
		logic       positive;
		logic [2:0] magnitude;
	} acr_conv_cfg_t;

	typedef enum logic {
		ACR_IDLE,
		ACR_BUSY
	} acr_state_t;

endpackage : acr_pkg

// ==== rtl/acr_top.sv ====
// Control and result registers of a four channel analog converter.
// Assumes a converter core that pulses done with a 12-bit raw result,
// a ring oscillator tick input, and a CPU register port.
// Operation
// - Each pin enable bit routes its port pin to converter when set.
// - Reference select 0 uses supply and leaves pin to timer clock or port; 1 uses pin.
// - Shared pin priority: reference, then timer clock, then port.
// - Divider codes: 00 /16, 01 /4, 10 /64, 11 ring oscillator.
// - Writing 1 to go starts; only completion clears it.
// - Power bit 0 switches off resistor reference; 1 operates.
// - Channel select code picks channel 0 to 3 in order.
// - Calibration enable applies offset correction when set.
// - Offset polarity 0 negative, 1 positive.
// - Offset magnitude is twice the field value in LSBs.
// - Low three trim bits read as zero.
// - Completion loads result bits 11..4 into upper result byte.
// - Completion clears go and sets done flag together.
// - Done flag set by hardware, cleared by software, read masked.
// - Completion loads full result into top nibble and low byte.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module acr_top (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic [3:0]            addr_i,
	input  wire logic [7:0]            wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [7:0]            rdata_o,
	output logic                       irq_o,
	input  wire logic                  timer_src_i,
	input  wire logic                  ring_tick_i,
	input  wire logic                  conv_done_i,
	input  wire logic [11:0]           conv_result_i,
	output logic                       conv_start_o,
	output logic                       conv_clk_en_o,
	output logic                       ref_from_pin_o,
	output logic                       ref_power_o,
	output logic [3:0]                 analog_pin_o,
	output logic                       pin_timer_o,
	output logic                       pin_port_o,
	output acr_pkg::acr_conv_cfg_t     conv_cfg_o
);

	// ==========================================================
	// State
	logic [7:0]             pin_sel_ff, nxt_pin_sel;
	logic [7:0]             ctrl_ff, nxt_ctrl;
	logic [7:0]             trim_ff, nxt_trim;
	logic [7:0]             mask_ff, nxt_mask;
	logic                   done_ff, nxt_done;
	logic [11:0]            result_ff, nxt_result;
	acr_pkg::acr_state_t    state_ff, nxt_state;
	acr_pkg::acr_conv_cfg_t cfg_ff, nxt_cfg;
	logic                   start_ff, nxt_start;
	logic [5:0]             div_cnt_ff, nxt_div_cnt;
	logic                   clk_en_ff, nxt_clk_en;
	logic [7:0]             rdata_ff, nxt_rdata;
	logic                   irq_ff, nxt_irq;
	logic [3:0]             pins_ff, nxt_pins;
	logic                   ref_pin_ff, nxt_ref_pin;
	logic                   power_ff, nxt_power;
	logic                   timer_ff, nxt_timer;
	logic                   port_ff, nxt_port;

	logic                   go_wr;
	logic                   completion;
	logic [5:0]             div_last;

	assign go_wr = wr_i && addr_i == acr_pkg::OFF_CONTROL
		&& wdata_i[acr_pkg::POS_GO];
	assign completion = (state_ff == acr_pkg::ACR_BUSY) && conv_done_i;

	// ==========================================================
	// Registers and conversion sequence
	always_comb begin
		nxt_pin_sel = pin_sel_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_trim    = trim_ff;
		nxt_mask    = mask_ff;
		nxt_done    = done_ff;
		nxt_result  = result_ff;
		nxt_state   = state_ff;
		nxt_cfg     = cfg_ff;
		nxt_start   = 1'b0;
		if (wr_i) begin
			unique case (addr_i)
				acr_pkg::OFF_PIN_SEL:
					nxt_pin_sel = wdata_i & acr_pkg::MASK_PIN_SEL;
				acr_pkg::OFF_CONTROL: begin
					// Go is sticky: software may set but not clear it
					nxt_ctrl = (wdata_i & acr_pkg::MASK_CONTROL)
						| (ctrl_ff & (8'h01 << acr_pkg::POS_GO));
					// Channel held while busy or done pending
					if (done_ff || ctrl_ff[acr_pkg::POS_GO]) begin
						nxt_ctrl[1:0] = ctrl_ff[1:0];
					end
				end
				acr_pkg::OFF_TRIM:
					nxt_trim = wdata_i & acr_pkg::MASK_TRIM;
				acr_pkg::OFF_IRQ_MASK:
					nxt_mask = wdata_i;
				default: ;
			endcase
		end
		// Status read clears the flag; hardware set below wins
		if (rd_i && addr_i == acr_pkg::OFF_IRQ_STAT) begin
			nxt_done = 1'b0;
		end
		if (wr_i && addr_i == acr_pkg::OFF_IRQ_STAT
			&& !wdata_i[acr_pkg::POS_DONE]) begin
			nxt_done = 1'b0;
		end
		unique case (state_ff)
			acr_pkg::ACR_IDLE: begin
				if (go_wr) begin
					nxt_state         = acr_pkg::ACR_BUSY;
					nxt_start         = 1'b1;
					nxt_cfg.channel   = nxt_ctrl[1:0];
					nxt_cfg.divider   = wdata_i[acr_pkg::POS_DIV_HI:
						acr_pkg::POS_DIV_LO];
					nxt_cfg.cal_en    = trim_ff[acr_pkg::POS_CAL_EN];
					nxt_cfg.positive  = trim_ff[acr_pkg::POS_SIGN];
					nxt_cfg.magnitude = trim_ff[acr_pkg::POS_MAG_HI:
						acr_pkg::POS_MAG_LO];
				end
			end
			acr_pkg::ACR_BUSY: begin
				if (conv_done_i) begin
					nxt_state = acr_pkg::ACR_IDLE;
				end
			end
		endcase
		if (completion) begin
			nxt_result = corrected(conv_result_i, cfg_ff);
			nxt_ctrl[acr_pkg::POS_GO] = 1'b0;
			nxt_done = 1'b1;
		end
	end

	// Offset of twice the field value, saturating at the range ends
	function automatic logic [11:0] corrected(
		input logic [11:0]              raw,
		input acr_pkg::acr_conv_cfg_t   cfg
	);
		logic [12:0] sum;
		logic [12:0] ofs;
		ofs = {9'h000, cfg.magnitude, 1'b0};
		sum = {1'b0, raw};
		if (!cfg.cal_en) begin
			corrected = raw;
		end else if (cfg.positive) begin
			sum = sum + ofs;
			corrected = sum[12] ? 12'hFFF : sum[11:0];
		end else begin
			corrected = (ofs > sum) ? 12'h000 : 12'(sum - ofs);
		end
	endfunction : corrected

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_sel_ff <= acr_pkg::RST_PIN_SEL;
			ctrl_ff    <= acr_pkg::RST_CONTROL;
			trim_ff    <= acr_pkg::RST_TRIM;
			mask_ff    <= acr_pkg::RST_MASK;
			done_ff    <= 1'b0;
			result_ff  <= 12'h000;
			state_ff   <= acr_pkg::ACR_IDLE;
			cfg_ff     <= '0;
			start_ff   <= 1'b0;
		end else begin
			pin_sel_ff <= nxt_pin_sel;
			ctrl_ff    <= nxt_ctrl;
			trim_ff    <= nxt_trim;
			mask_ff    <= nxt_mask;
			done_ff    <= nxt_done;
			result_ff  <= nxt_result;
			state_ff   <= nxt_state;
			cfg_ff     <= nxt_cfg;
			start_ff   <= nxt_start;
		end
	end

	// ==========================================================
	// Conversion clock enable
	always_comb begin
		unique case (cfg_ff.divider)
			acr_pkg::DIV_4:  div_last = 6'(acr_pkg::DIV_4_N - 1);
			acr_pkg::DIV_64: div_last = 6'(acr_pkg::DIV_64_N - 1);
			default:         div_last = 6'(acr_pkg::DIV_16_N - 1);
		endcase
		nxt_div_cnt = 6'h00;
		nxt_clk_en  = 1'b0;
		if (state_ff == acr_pkg::ACR_BUSY) begin
			if (cfg_ff.divider == acr_pkg::DIV_RING) begin
				nxt_clk_en = ring_tick_i;
			end else if (div_cnt_ff >= div_last) begin
				nxt_clk_en = 1'b1;
			end else begin
				nxt_div_cnt = div_cnt_ff + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_ff <= 6'h00;
			clk_en_ff  <= 1'b0;
		end else begin
			div_cnt_ff <= nxt_div_cnt;
			clk_en_ff  <= nxt_clk_en;
		end
	end

	// ==========================================================
	// Read port, interrupt and pin routing
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				acr_pkg::OFF_PIN_SEL:   nxt_rdata = pin_sel_ff;
				acr_pkg::OFF_CONTROL:   nxt_rdata = ctrl_ff;
				acr_pkg::OFF_TRIM:      nxt_rdata = trim_ff;
				acr_pkg::OFF_RES_UPPER: nxt_rdata = result_ff[11:4];
				acr_pkg::OFF_RES_TOP:
					nxt_rdata = {4'h0, result_ff[11:8]};
				acr_pkg::OFF_RES_LOW:   nxt_rdata = result_ff[7:0];
				acr_pkg::OFF_IRQ_STAT:
					nxt_rdata = {2'h0, done_ff & mask_ff[acr_pkg::POS_DONE],
						5'h00};
				acr_pkg::OFF_IRQ_MASK:  nxt_rdata = mask_ff;
				default:                nxt_rdata = 8'h00;
			endcase
		end
		nxt_irq     = nxt_done && nxt_mask[acr_pkg::POS_DONE];
		nxt_pins    = nxt_pin_sel[3:0];
		nxt_ref_pin = nxt_ctrl[acr_pkg::POS_REF_SEL];
		nxt_power   = nxt_ctrl[acr_pkg::POS_POWER];
		// Reference wins the pin even if software breaks the timer rule
		nxt_timer   = !nxt_ref_pin && timer_src_i;
		nxt_port    = !nxt_ref_pin && !timer_src_i;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff   <= 8'h00;
			irq_ff     <= 1'b0;
			pins_ff    <= 4'h0;
			ref_pin_ff <= 1'b0;
			power_ff   <= 1'b0;
			timer_ff   <= 1'b0;
			port_ff    <= 1'b1;
		end else begin
			rdata_ff   <= nxt_rdata;
			irq_ff     <= nxt_irq;
			pins_ff    <= nxt_pins;
			ref_pin_ff <= nxt_ref_pin;
			power_ff   <= nxt_power;
			timer_ff   <= nxt_timer;
			port_ff    <= nxt_port;
		end
	end

	assign rdata_o        = rdata_ff;
	assign irq_o          = irq_ff;
	assign conv_start_o   = start_ff;
	assign conv_clk_en_o  = clk_en_ff;
	assign ref_from_pin_o = ref_pin_ff;
	assign ref_power_o    = power_ff;
	assign analog_pin_o   = pins_ff;
	assign pin_timer_o    = timer_ff;
	assign pin_port_o     = port_ff;
	assign conv_cfg_o     = cfg_ff;

endmodule : acr_top

// ==== verification/acr_assertions.sv ====
// Port checker for the converter control register block.
// Assumes it is bound onto acr_top; one clock, reset active high.
`timescale 1ns/1ps
module acr_assertions (
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic [3:0]             addr_i,
	input wire logic [7:0]             wdata_i,
	input wire logic                   wr_i,
	input wire logic                   rd_i,
	input wire logic [7:0]             rdata_o,
	input wire logic                   irq_o,
	input wire logic                   conv_done_i,
	input wire logic                   conv_start_o,
	input wire logic                   ref_from_pin_o,
	input wire logic                   ref_power_o,
	input wire logic [3:0]             analog_pin_o,
	input wire logic                   pin_timer_o,
	input wire logic                   pin_port_o,
	input wire acr_pkg::acr_conv_cfg_t conv_cfg_o
);
	// ==========================================================
	// Register and pin relations
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_rd(logic [3:0] a);
		rd_i && addr_i == a;
	endsequence
	sequence s_wr(logic [3:0] a);
		wr_i && addr_i == a;
	endsequence
	property p_start;
		conv_start_o |-> $past(wr_i && wdata_i[4])
			&& $past(addr_i) == acr_pkg::OFF_CONTROL;
	endproperty
	a_start: assert property (p_start) else $error("start without go");
	property p_pin;
		s_wr(acr_pkg::OFF_PIN_SEL) |=> analog_pin_o == $past(wdata_i[3:0]);
	endproperty
	a_pin: assert property (p_pin) else $error("pin enables wrong");
	property p_ctl;
		s_wr(acr_pkg::OFF_CONTROL) |=> ref_from_pin_o == $past(wdata_i[7])
			&& ref_power_o == $past(wdata_i[3]);
	endproperty
	a_ctl: assert property (p_ctl) else $error("ref or power wrong");
	property p_prio;
		$onehot({ref_from_pin_o, pin_timer_o, pin_port_o});
	endproperty
	a_prio: assert property (p_prio) else $error("shared pin clash");
	property p_cfg;
		$changed(conv_cfg_o) |-> conv_start_o;
	endproperty
	a_cfg: assert property (p_cfg) else $error("settings moved");
	property p_trim;
		s_rd(acr_pkg::OFF_TRIM) |=> rdata_o[2:0] == 3'h0;
	endproperty
	a_trim: assert property (p_trim) else $error("trim low bits set");
	property p_stat;
		s_rd(acr_pkg::OFF_IRQ_STAT) |=> rdata_o[5] == $past(irq_o);
	endproperty
	a_stat: assert property (p_stat) else $error("status not masked");
	property p_irq;
		s_rd(acr_pkg::OFF_IRQ_STAT) ##0 !conv_done_i |=> !irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("flag not cleared");
endmodule : acr_assertions

// ==== verification/acr_core_model.sv ====
// Behavioural converter core on the far side of the register block.
// Assumes the bench sets the result value and conversion length.
`timescale 1ns/1ps
module acr_core_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        start_i,
	input  wire logic        clk_en_i,
	input  wire logic [3:0]  steps_i,
	input  wire logic [11:0] value_i,
	input  wire logic        stray_i,
	output logic             done_o,
	output logic [11:0]      result_o,
	output logic             ring_tick_o
);
	logic       busy_ff;
	logic [3:0] cnt_ff;
	logic [2:0] ring_ff;
	logic       fire;
	// Length counted in divided clock ticks, so every divider matters
	assign fire = busy_ff && clk_en_i && cnt_ff == steps_i;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_ff     <= 1'b0;
			cnt_ff      <= 4'h0;
			ring_ff     <= 3'h0;
			done_o      <= 1'b0;
			result_o    <= 12'h000;
			ring_tick_o <= 1'b0;
		end else begin
			ring_ff     <= ring_ff + 3'h1;
			ring_tick_o <= ring_ff == 3'h7;
			// Stray pulse only on command, to test that idle done is ignored
			done_o      <= fire || (stray_i && !busy_ff);
			// Outside the done cycle the result lines keep toggling
			result_o    <= fire ? value_i : ~result_o;
			if (start_i) begin
				busy_ff <= 1'b1;
				cnt_ff  <= 4'h0;
			end else if (busy_ff && clk_en_i) begin
				cnt_ff  <= cnt_ff + 4'h1;
				busy_ff <= !fire;
			end
		end
	end
endmodule : acr_core_model

// ==== verification/tb.sv ====
// Self-checking bench for the converter control register block.
// Assumes the checker and core model are compiled before it.
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [3:0]  addr_i = 4'h0;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        timer_src_i = 1'b0;
	logic [3:0]  steps = 4'h2;
	logic [11:0] value = 12'h000;
	logic        stray = 1'b0;
	logic        rd_d = 1'b0;
	int          div_n = 0;
	int          en_gap = 0;
	logic [3:0]  pin_state;
	logic [7:0]  rdata_o;
	logic        irq_o, ring_tick_i, conv_done_i, conv_start_o;
	logic        conv_clk_en_o, ref_from_pin_o, ref_power_o;
	logic        pin_timer_o, pin_port_o;
	logic [3:0]  analog_pin_o;
	logic [11:0] conv_result_i;
	logic [11:0] exp_q[$];
	logic [31:0] seed = 32'hAD7B4598;
	int          err_total = 0;
	int          tests_run = 0;
	acr_pkg::acr_conv_cfg_t conv_cfg_o;

	always #25 clk_i = ~clk_i;
	assign pin_state = {ref_from_pin_o, ref_power_o, pin_timer_o, pin_port_o};

	acr_top dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.irq_o(irq_o), .timer_src_i(timer_src_i), .ring_tick_i(ring_tick_i),
		.conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
		.conv_start_o(conv_start_o), .conv_clk_en_o(conv_clk_en_o),
		.ref_from_pin_o(ref_from_pin_o), .ref_power_o(ref_power_o),
		.analog_pin_o(analog_pin_o), .pin_timer_o(pin_timer_o),
		.pin_port_o(pin_port_o), .conv_cfg_o(conv_cfg_o));
	acr_core_model core (.clk_i(clk_i), .rst_i(rst_i),
		.start_i(conv_start_o), .clk_en_i(conv_clk_en_o), .steps_i(steps),
		.value_i(value), .stray_i(stray), .done_o(conv_done_i),
		.result_o(conv_result_i), .ring_tick_o(ring_tick_i));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [11:0] adj(input logic [11:0] r,
		input logic [7:0] t);
		int v;
		v = int'(r);
		if (t[7])
			v = t[6] ? v + 2 * int'(t[5:3]) : v - 2 * int'(t[5:3]);
		v = v < 0 ? 0 : (v > 4095 ? 4095 : v);
		return v[11:0];
	endfunction : adj
	task automatic chk(input logic [11:0] e, input logic [11:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: exp %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	// A gap cycle follows each access so no strobe is set twice at once
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		exp_q.push_back({4'h0, e});
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
	endtask : rd
	// Read data stand only in the cycle after the strobe
	always @(posedge clk_i) begin
		if (rd_d)
			chk(exp_q.pop_front(), {4'h0, rdata_o});
		rd_d <= rd_i;
	end
	// Divided enable period, from start and between pulses
	always @(posedge clk_i) begin
		if (conv_clk_en_o === 1'b1 && div_n != 0)
			chk(12'(div_n), 12'(en_gap));
		en_gap <= (conv_start_o || conv_clk_en_o) ? 1 : en_gap + 1;
	end
	initial begin
		#(50 * 30000);
		err_total++;
		test_done();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0]  ctl;
		logic [7:0]  tr;
		logic [11:0] res;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int a = 0; a < 16; a++)
			rd(a[3:0], 8'h00);
		seed = lfsr(seed);
		wr(acr_pkg::OFF_PIN_SEL, seed[7:0] | 8'hF0);
		chk({8'h0, seed[3:0]}, {8'h0, analog_pin_o});
		rd(acr_pkg::OFF_PIN_SEL, seed[7:0] & acr_pkg::MASK_PIN_SEL);
		wr(acr_pkg::OFF_TRIM, 8'hFF);
		rd(acr_pkg::OFF_TRIM, 8'hF8);
		// Timer source stays low while the pin is the reference
		wr(acr_pkg::OFF_CONTROL, 8'h8C);
		rd(acr_pkg::OFF_CONTROL, 8'h88);
		chk(12'hC, {8'h0, pin_state});
		timer_src_i <= 1'b1;
		wr(acr_pkg::OFF_CONTROL, 8'h00);
		chk(12'h2, {8'h0, pin_state});
		timer_src_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(12'h1, {8'h0, pin_state});
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			// Offset on from the second pass, magnitude odd and growing
			tr = {(i != 0), i[0], i[1:0], 1'b1, 3'h0};
			// Tiny sample on the negative pass pushes the result below zero
			value <= (i == 2) ? {10'h000, seed[17:16]} : seed[27:16];
			div_n = (i == 0) ? acr_pkg::DIV_16_N
				: (i == 1) ? acr_pkg::DIV_4_N
				: (i == 2) ? acr_pkg::DIV_64_N : 0;
			steps <= {2'h0, seed[1:0]} + 4'h2;
			ctl = {1'b0, i[1:0], 2'h3, 1'b0, seed[9:8]};
			wr(acr_pkg::OFF_IRQ_MASK, {2'h0, i[0], 5'h0});
			wr(acr_pkg::OFF_TRIM, tr);
			wr(acr_pkg::OFF_CONTROL, ctl);
			chk({3'h0, seed[9:8], i[1:0], tr[7:3]},
				{3'h0, conv_cfg_o});
			wr(acr_pkg::OFF_CONTROL, ctl ^ 8'h13);
			rd(acr_pkg::OFF_CONTROL, ctl);
			for (int n = 0; n < 2000 && conv_done_i !== 1'b1; n++)
				@(posedge clk_i);
			// A conversion that never ends is a failure by itself
			if (conv_done_i !== 1'b1)
				err_total++;
			@(posedge clk_i);
			chk({11'h0, i[0]}, {11'h0, irq_o});
			res = adj(value, tr);
			rd(acr_pkg::OFF_RES_UPPER, res[11:4]);
			rd(acr_pkg::OFF_RES_TOP, {4'h0, res[11:8]});
			rd(acr_pkg::OFF_RES_LOW, res[7:0]);
			rd(acr_pkg::OFF_CONTROL, ctl & 8'hEF);
			wr(acr_pkg::OFF_IRQ_MASK, 8'h20);
			// Later passes clear by writing zero, earlier ones by reading
			if (i[1])
				wr(acr_pkg::OFF_IRQ_STAT, 8'hDF);
			rd(acr_pkg::OFF_IRQ_STAT, i[1] ? 8'h00 : 8'h20);
			chk(12'h0, {11'h0, irq_o});
		end
		stray <= 1'b1;
		@(posedge clk_i);
		stray <= 1'b0;
		repeat (3) @(posedge clk_i);
		rd(acr_pkg::OFF_IRQ_STAT, 8'h00);
		rd(acr_pkg::OFF_RES_LOW, res[7:0]);
		// Software may not set the done flag
		wr(acr_pkg::OFF_IRQ_STAT, 8'hFF);
		rd(acr_pkg::OFF_IRQ_STAT, 8'h00);
		@(posedge clk_i);
		test_done();
	end
endmodule : tb

bind acr_top acr_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .irq_o(irq_o), .conv_done_i(conv_done_i),
	.conv_start_o(conv_start_o), .ref_from_pin_o(ref_from_pin_o),
	.ref_power_o(ref_power_o), .analog_pin_o(analog_pin_o),
	.pin_timer_o(pin_timer_o), .pin_port_o(pin_port_o),
	.conv_cfg_o(conv_cfg_o));
